// ---- hw/bcp_pkg.sv ----
// constants and operation codes for the bit-manipulation and compare-pick unit
// assumes the pipeline decodes instructions into one op code per request
package bcp_pkg;

  typedef enum logic [4:0] {
    OP_NONE         = 5'h00,
    OP_BIT_MIRROR   = 5'h01,
    OP_FIELD_PUT    = 5'h02,
    OP_BYTE_SPLAT   = 5'h03,
    OP_BYTE_SPLATR  = 5'h04,
    OP_HALF_SPLAT   = 5'h05,
    OP_HALF_SPLATR  = 5'h06,
    OP_BCMP_FLAGS   = 5'h07,
    OP_BCMP_GPR     = 5'h08,
    OP_BCMP_DUAL    = 5'h09,
    OP_HCMP_FLAGS   = 5'h0a,
    OP_BYTE_SELECT  = 5'h0b,
    OP_HALF_SELECT  = 5'h0c,
    OP_MERGE_LEFT   = 5'h0d,
    OP_MERGE_RIGHT  = 5'h0e,
    OP_BYTE_ALIGN   = 5'h0f,
    OP_CROSS_PACK   = 5'h10
  } op_e;

  typedef enum logic [1:0] {
    CMP_EQ = 2'h0,
    CMP_LT = 2'h1,
    CMP_LE = 2'h2
  } cmp_e;

  localparam int LEN_LSB   = 10;
  localparam int LEN_MSB   = 14;
  localparam int POS_LSB   = 16;
  localparam int POS_MSB   = 20;
  localparam int CC_LSB    = 24;
  localparam int CC_W      = 4;
  localparam logic [63:0] RESULT_RESET = 64'h0;
  localparam logic [3:0]  CC_RESET     = 4'h0;

endpackage

// ---- hw/bcp_lane_cmp.sv ----
// one comparison lane: equal, less-than or less-or-equal
// assumes operands and mode come from the same clock domain
`timescale 1ns/10ps
`default_nettype none
module bcp_lane_cmp #(
  parameter int W = 8
) (
  input  wire logic [W-1:0]      i_a,      // left operand
  input  wire logic [W-1:0]      i_b,      // right operand
  input  wire logic              i_signed, // signed compare
  input  wire bcp_pkg::cmp_e     i_mode,   // compare kind
  output logic                   o_res     // boolean result
);
  import bcp_pkg::*;
  logic lt;
  logic eq;
  always_comb begin
    eq = (i_a == i_b);
    lt = i_signed ? ($signed(i_a) < $signed(i_b)) : (i_a < i_b);
    unique case (i_mode)
      CMP_EQ:  o_res = eq;
      CMP_LT:  o_res = lt;
      CMP_LE:  o_res = lt | eq;
      default: o_res = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ---- hw/bcp_field_put.sv ----
// bitfield insert: low len bits of src placed into dst at pos
// assumes pos+len fits the 32-bit word; larger fields are clipped
`timescale 1ns/10ps
`default_nettype none
module bcp_field_put (
  input  wire logic [31:0] i_src, // field source
  input  wire logic [31:0] i_dst, // word to modify
  input  wire logic [4:0]  i_len, // field length
  input  wire logic [4:0]  i_pos, // field position
  output logic      [31:0] o_res  // modified word
);
  logic [31:0] mask;
  always_comb begin
    mask  = ((32'h1 << i_len) - 32'h1) << i_pos;
    o_res = (i_dst & ~mask) | ((i_src << i_pos) & mask);
  end
endmodule
`default_nettype wire

// ---- hw/bcp_unit.sv ----
// execution datapath for bit-manipulation and compare-pick operations
// assumes the pipeline holds decoded operands stable for the request cycle
`timescale 1ns/10ps
`default_nettype none
module bcp_unit (
  input  wire logic             I_REF_CLK,   // core clock
  input  wire logic             I_SRST,      // sync reset, active high
  input  wire logic             I_VALID,     // request strobe
  input  wire bcp_pkg::op_e     I_OP,        // decoded operation
  input  wire bcp_pkg::cmp_e    I_CMP,       // compare kind
  input  wire logic [63:0]      I_SRC_ONE,   // source_one_gpr
  input  wire logic [63:0]      I_SRC_TWO,   // source_two_gpr
  input  wire logic [9:0]       I_IMM,       // 10-bit immediate
  input  wire logic [4:0]       I_SHIFT,     // merge_shift_amount
  input  wire logic [1:0]       I_BYTE_CNT,  // byte_count_sel
  input  wire logic [31:0]      I_CTRL,      // dsp_control_reg
  output logic                  O_VALID,     // result strobe
  output logic [63:0]           O_RESULT,    // destination value
  output logic                  O_GPR_WE,    // write a general register
  output logic                  O_TO_SRC2,   // destination is source_two
  output logic                  O_CC_WE,     // write condition bits
  output logic [3:0]            O_CC_MASK,   // condition bits written
  output logic [3:0]            O_CC         // condition bit values
);
  import bcp_pkg::*;

  logic [31:0] a;
  logic [31:0] b;
  logic [3:0]  cc;
  logic [3:0]  bcmp;
  logic [1:0]  hcmp;
  logic [31:0] put_res;
  logic [63:0] next_result;
  logic        next_gpr_we;
  logic        next_to_src2;
  logic        next_cc_we;
  logic [3:0]  next_cc_mask;
  logic [3:0]  next_cc;
  logic [31:0] w;
  logic [31:0] ones;
  logic [63:0] cat;
  logic [15:0] himm;

  assign a  = I_SRC_ONE[31:0];
  assign b  = I_SRC_TWO[31:0];
  assign cc = I_CTRL[CC_LSB +: CC_W];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_byte
      bcp_lane_cmp #(.W(8)) u_bcmp (
        .i_a      (a[8*g +: 8]),
        .i_b      (b[8*g +: 8]),
        .i_signed (1'b0),
        .i_mode   (I_CMP),
        .o_res    (bcmp[g])
      );
    end
    for (g = 0; g < 2; g++) begin : g_half
      bcp_lane_cmp #(.W(16)) u_hcmp (
        .i_a      (a[16*g +: 16]),
        .i_b      (b[16*g +: 16]),
        .i_signed (1'b1),
        .i_mode   (I_CMP),
        .o_res    (hcmp[g])
      );
    end
  endgenerate

  bcp_field_put u_put (
    .i_src (a),
    .i_dst (b),
    .i_len (I_CTRL[LEN_MSB:LEN_LSB]),
    .i_pos (I_CTRL[POS_MSB:POS_LSB]),
    .o_res (put_res)
  );

  always_comb begin
    next_result  = RESULT_RESET;
    next_gpr_we  = 1'b1;
    next_to_src2 = 1'b0;
    next_cc_we   = 1'b0;
    next_cc_mask = 4'h0;
    next_cc      = CC_RESET;
    w            = 32'h0;
    ones         = 32'h0;
    cat          = 64'h0;
    himm         = {{6{I_IMM[9]}}, I_IMM};
    unique case (I_OP)
      OP_BIT_MIRROR: begin
        for (int i = 0; i < 16; i++) begin
          next_result[15-i] = b[i];
        end
        // upper bits stay at the zero default
      end
      OP_FIELD_PUT: begin
        next_to_src2 = 1'b1;
        next_result  = {{32{put_res[31]}}, put_res};
      end
      OP_BYTE_SPLAT: begin
        w           = {4{I_IMM[7:0]}};
        next_result = {{32{w[31]}}, w};
      end
      OP_BYTE_SPLATR: begin
        w           = {4{b[7:0]}};
        next_result = {{32{w[31]}}, w};
      end
      OP_HALF_SPLAT: begin
        w           = {2{himm}};
        next_result = {{32{w[31]}}, w};
      end
      OP_HALF_SPLATR: begin
        w           = {2{b[15:0]}};
        next_result = {{32{w[31]}}, w};
      end
      OP_BCMP_FLAGS: begin
        next_gpr_we  = 1'b0;
        next_cc_we   = 1'b1;
        next_cc_mask = 4'hf;
        next_cc      = bcmp;
      end
      OP_BCMP_GPR: begin
        next_result = {60'h0, bcmp};
      end
      OP_BCMP_DUAL: begin
        next_result  = {60'h0, bcmp};
        next_cc_we   = 1'b1;
        next_cc_mask = 4'hf;
        next_cc      = bcmp;
      end
      OP_HCMP_FLAGS: begin
        next_gpr_we  = 1'b0;
        next_cc_we   = 1'b1;
        next_cc_mask = 4'h3;
        next_cc      = {2'h0, hcmp};
      end
      OP_BYTE_SELECT: begin
        for (int i = 0; i < 4; i++) begin
          w[8*i +: 8] = cc[i] ? a[8*i +: 8] : b[8*i +: 8];
        end
        next_result = {{32{w[31]}}, w};
      end
      OP_HALF_SELECT: begin
        for (int i = 0; i < 2; i++) begin
          w[16*i +: 16] = cc[i] ? a[16*i +: 16] : b[16*i +: 16];
        end
        next_result = {{32{w[31]}}, w};
      end
      OP_MERGE_LEFT: begin
        ones         = (32'h1 << I_SHIFT) - 32'h1;
        w            = (b << I_SHIFT) | (a & ones);
        next_to_src2 = 1'b1;
        next_result  = {{32{w[31]}}, w};
      end
      OP_MERGE_RIGHT: begin
        cat          = {a, b} >> I_SHIFT;
        w            = cat[31:0];
        next_to_src2 = 1'b1;
        next_result  = {{32{w[31]}}, w};
      end
      OP_BYTE_ALIGN: begin
        unique case (I_BYTE_CNT)
          2'h0: w = a;
          2'h1: w = {b[7:0], a[31:8]};
          2'h2: w = {b[15:0], a[31:16]};
          2'h3: w = {b[23:0], a[31:24]};
        endcase
        next_to_src2 = 1'b1;
        next_result  = {{32{w[31]}}, w};
      end
      OP_CROSS_PACK: begin
        w           = {a[15:0], b[31:16]};
        next_result = {{32{w[31]}}, w};
      end
      default: begin
        next_gpr_we = 1'b0;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      O_VALID <= 1'b0;
    end else begin
      O_VALID <= I_VALID && (I_OP != OP_NONE);
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      O_RESULT  <= RESULT_RESET;
      O_GPR_WE  <= 1'b0;
      O_TO_SRC2 <= 1'b0;
      O_CC_WE   <= 1'b0;
      O_CC_MASK <= 4'h0;
      O_CC      <= CC_RESET;
    end else begin
      O_RESULT  <= next_result;
      O_GPR_WE  <= I_VALID && next_gpr_we;
      O_TO_SRC2 <= next_to_src2;
      O_CC_WE   <= I_VALID && next_cc_we;
      O_CC_MASK <= next_cc_mask;
      O_CC      <= next_cc;
    end
  end

  // checks
  a_mirror_upper_zero: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
    I_VALID && I_OP == OP_BIT_MIRROR |=> O_RESULT[63:16] == 48'h0 && O_RESULT[15] == $past(b[0]))
    else $error("mirror result wrong");
  a_mirror_bit_order: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
    I_VALID && I_OP == OP_BIT_MIRROR |=> O_RESULT[0] == $past(b[15]))
    else $error("mirror low bit wrong");
  a_flags_no_gpr: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
    I_VALID && I_OP == OP_BCMP_FLAGS |=> O_CC_WE && !O_GPR_WE && O_CC_MASK == 4'hf)
    else $error("flag compare wrote gpr");
  a_gpr_cmp_no_cc: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
    I_VALID && I_OP == OP_BCMP_GPR |=> O_GPR_WE && !O_CC_WE && O_RESULT[63:4] == 60'h0)
    else $error("gpr compare touched flags");
  a_dual_cmp_same: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
    I_VALID && I_OP == OP_BCMP_DUAL |=> O_CC_WE && O_GPR_WE && O_CC == O_RESULT[3:0])
    else $error("dual compare mismatch");
  a_half_cmp_mask: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
    I_VALID && I_OP == OP_HCMP_FLAGS |=> O_CC_MASK == 4'h3 && O_CC[3:2] == 2'h0)
    else $error("halfword compare mask wrong");
  a_splat_sign_ext: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
    I_VALID && I_OP == OP_BYTE_SPLATR |=> O_RESULT[7:0] == O_RESULT[31:24]
      && O_RESULT[63:32] == {32{O_RESULT[31]}})
    else $error("splat result wrong");
  a_merge_to_src2: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
    I_VALID && (I_OP == OP_MERGE_LEFT || I_OP == OP_MERGE_RIGHT)
      |=> O_TO_SRC2 && O_RESULT[63:32] == {32{O_RESULT[31]}})
    else $error("merge result not extended");
  a_pack_halves: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
    I_VALID && I_OP == OP_CROSS_PACK |=> O_RESULT[31:16] == $past(a[15:0]))
    else $error("pack upper half wrong");
  a_pack_low_half: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
    I_VALID && I_OP == OP_CROSS_PACK |=> O_RESULT[15:0] == $past(b[31:16]))
    else $error("pack lower half wrong");
  a_put_field_base: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
    I_VALID && I_OP == OP_FIELD_PUT && I_CTRL[LEN_MSB:LEN_LSB] != 5'h0
      |=> ((O_RESULT[31:0] >> $past(I_CTRL[POS_MSB:POS_LSB])) & 32'h1) == {31'h0, $past(a[0])})
    else $error("field put base bit wrong");
  a_splat_byte_imm: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
    I_VALID && I_OP == OP_BYTE_SPLAT |=> O_RESULT[31:0] == {4{$past(I_IMM[7:0])}})
    else $error("byte splat lanes wrong");
  a_splat_half_imm: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
    I_VALID && I_OP == OP_HALF_SPLAT |=> O_RESULT[31:16] == O_RESULT[15:0]
      && O_RESULT[15:0] == {{6{$past(I_IMM[9])}}, $past(I_IMM)})
    else $error("halfword splat lanes wrong");
  a_select_byte_lane: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
    I_VALID && I_OP == OP_BYTE_SELECT
      |=> O_RESULT[7:0] == ($past(cc[0]) ? $past(a[7:0]) : $past(b[7:0])))
    else $error("byte select lane wrong");
  a_select_half_lane: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
    I_VALID && I_OP == OP_HALF_SELECT
      |=> O_RESULT[31:16] == ($past(cc[1]) ? $past(a[31:16]) : $past(b[31:16])))
    else $error("halfword select lane wrong");
  a_merge_left_byte: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
    I_VALID && I_OP == OP_MERGE_LEFT && I_SHIFT == 5'h8
      |=> O_RESULT[31:0] == {$past(b[23:0]), $past(a[7:0])})
    else $error("left merge fill wrong");
  a_merge_right_fill: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
    I_VALID && I_OP == OP_MERGE_RIGHT && I_SHIFT == 5'h4
      |=> O_RESULT[31:0] == {$past(a[3:0]), $past(b[31:4])})
    else $error("right merge fill wrong");
  a_align_one_byte: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
    I_VALID && I_OP == OP_BYTE_ALIGN && I_BYTE_CNT == 2'h1
      |=> O_RESULT[31:0] == {$past(b[7:0]), $past(a[31:8])} && O_TO_SRC2)
    else $error("byte align order wrong");
  c_byte_cmp_dual: cover property (@(posedge I_REF_CLK) I_VALID && I_OP == OP_BCMP_DUAL);
  c_merge_left:    cover property (@(posedge I_REF_CLK) I_VALID && I_OP == OP_MERGE_LEFT);
  c_byte_select:   cover property (@(posedge I_REF_CLK) I_VALID && I_OP == OP_BYTE_SELECT);
  c_field_put:     cover property (@(posedge I_REF_CLK) I_VALID && I_OP == OP_FIELD_PUT);
endmodule
`default_nettype wire

// ---- sim/bcp_pipe_model.sv ----
// pipeline writeback model: dest, source_two and condition bits
// assumes the unit's strobes are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
module bcp_pipe_model (
  input  wire logic        i_clk,     // core clock
  input  wire logic        i_srst,    // sync reset
  input  wire logic        i_valid,   // result strobe
  input  wire logic        i_gpr_we,  // gpr write
  input  wire logic        i_to_src2, // write source_two
  input  wire logic        i_cc_we,   // cc write
  input  wire logic [3:0]  i_cc_mask, // cc bits written
  input  wire logic [3:0]  i_cc,      // cc values
  input  wire logic [63:0] i_result,  // result
  output logic      [63:0] o_dest,    // dest image
  output logic      [63:0] o_src2,    // source_two image
  output logic      [3:0]  o_cc       // condition bits
);
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_dest <= 64'h0;
      o_src2 <= 64'h0;
    end else if (i_valid && i_gpr_we) begin
      if (i_to_src2) begin
        o_src2 <= i_result;
      end else begin
        o_dest <= i_result;
      end
    end
  end
  // only masked bits change
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_cc <= 4'h0;
    end else if (i_valid && i_cc_we) begin
      o_cc <= (o_cc & ~i_cc_mask) | (i_cc & i_cc_mask);
    end
  end
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// self-checking bench for the bit-manipulation and compare-pick unit
// assumes bcp_pkg and the unit are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import bcp_pkg::*;
  logic        clk = 0, srst = 1, valid = 0;
  op_e         op = OP_NONE;
  cmp_e        cmpk = CMP_EQ;
  logic [63:0] s1 = 0, s2 = 0, res, pd, ps;
  logic [9:0]  imm = 0;
  logic [4:0]  sh = 0;
  logic [1:0]  bc = 0;
  logic [31:0] ctrl = 0;
  logic        ov, gwe, to2, cwe;
  logic [3:0]  cmask, cc, pcc;
  int          bad_count = 0, checks = 0, cyc = 0;
  always #5 clk = ~clk;
  bcp_unit bcp_unit_inst (.I_REF_CLK(clk), .I_SRST(srst), .I_VALID(valid), .I_OP(op),
    .I_CMP(cmpk), .I_SRC_ONE(s1), .I_SRC_TWO(s2), .I_IMM(imm), .I_SHIFT(sh),
    .I_BYTE_CNT(bc), .I_CTRL(ctrl), .O_VALID(ov), .O_RESULT(res), .O_GPR_WE(gwe),
    .O_TO_SRC2(to2), .O_CC_WE(cwe), .O_CC_MASK(cmask), .O_CC(cc));
  bcp_pipe_model bcp_pipe_model_inst (.i_clk(clk), .i_srst(srst), .i_valid(ov),
    .i_gpr_we(gwe), .i_to_src2(to2), .i_cc_we(cwe), .i_cc_mask(cmask), .i_cc(cc),
    .i_result(res), .o_dest(pd), .o_src2(ps), .o_cc(pcc));
  task automatic print_verdict;
    if (bad_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // idle edge first, then one request; ends at the negedge where its answer stands
  task automatic go(input op_e o, input logic [31:0] a, input logic [31:0] b);
    @(negedge clk);
    op = o;
    s1 = {~a, a};
    s2 = {~b, b};
    valid = 1;
    @(negedge clk);
    valid = 0;
  endtask
  // strobes: valid, gpr write, to source_two, cc write
  task automatic st(input logic [3:0] e);
    chk({60'h0, ov, gwe, to2, cwe}, {60'h0, e});
  endtask
  task automatic t_mirror;
    logic [15:0] v, r;
    v = 16'hb3c1;
    for (int i = 0; i < 16; i++) begin
      r[15-i] = v[i];
    end
    go(OP_BIT_MIRROR, 32'h5a5a0000, 32'hffffb3c1);
    chk(res, {48'h0, r});
    st(4'hc);
  endtask
  task automatic t_field;
    ctrl = 32'h0018_2000;
    sh = 5'h3;
    go(OP_FIELD_PUT, 32'h0000_00a5, 32'h0000_1234);
    chk(res, 64'hffffffff_a5001234);
    st(4'he);
    ctrl = 32'h0000_1000;
    go(OP_FIELD_PUT, 32'h0000_00ff, 32'h1234_5670);
    chk(res, 64'h1234567f);
  endtask
  task automatic t_splat;
    imm = 10'h2a5;
    go(OP_BYTE_SPLAT, 32'h0, 32'h77);
    chk(res, 64'hffffffff_a5a5a5a5);
    go(OP_BYTE_SPLATR, 32'h0, 32'h1234563c);
    chk(res, 64'h3c3c3c3c);
    imm = 10'h200;
    go(OP_HALF_SPLAT, 32'h0, 32'h0);
    chk(res, 64'hffffffff_fe00fe00);
    go(OP_HALF_SPLATR, 32'h0, 32'hffff1234);
    chk(res, 64'h12341234);
    st(4'hc);
  endtask
  task automatic t_cmp;
    logic [3:0] ex [3] = '{4'b1001, 4'b0100, 4'b1101};
    logic [1:0] hx [3] = '{2'b01, 2'b10, 2'b11};
    for (int k = 0; k < 3; k++) begin
      cmpk = cmp_e'(k);
      go(OP_BCMP_FLAGS, 32'h10208040, 32'h10307f40);
      chk({52'h0, cmask, cc, ov, gwe, to2, cwe}, {52'h0, 4'hf, ex[k], 4'h9});
      go(OP_BCMP_GPR, 32'h10208040, 32'h10307f40);
      chk(res, {60'h0, ex[k]});
      st(4'hc);
      @(negedge clk);
      chk({60'h0, pcc}, {60'h0, ex[k]});
      chk(pd, {60'h0, ex[k]});
      go(OP_BCMP_DUAL, 32'h10208040, 32'h10307f40);
      chk(res, {60'h0, ex[k]});
      chk({56'h0, cmask, cc}, {56'h0, 4'hf, ex[k]});
      st(4'hd);
      go(OP_HCMP_FLAGS, 32'h80000005, 32'h7fff0005);
      chk({58'h0, cmask, cc[1:0]}, {58'h0, 4'h3, hx[k]});
      st(4'h9);
    end
  endtask
  task automatic t_select;
    cmpk = CMP_LT;
    go(OP_BCMP_FLAGS, 32'h05101005, 32'h05202005);
    @(negedge clk);
    chk({60'h0, pcc}, 64'h6);
    ctrl = {4'h0, pcc, 24'h0};
    go(OP_BYTE_SELECT, 32'h11223344, 32'haabbccdd);
    chk(res, 64'hffffffff_aa2233dd);
    go(OP_HALF_SELECT, 32'h11223344, 32'haabbccdd);
    chk(res, 64'h1122ccdd);
  endtask
  task automatic t_merge;
    sh = 5'd8;
    go(OP_MERGE_LEFT, 32'h000000ab, 32'h81234567);
    chk(res, 64'h234567ab);
    st(4'he);
    sh = 5'd0;
    go(OP_MERGE_LEFT, 32'hff, 32'h81234567);
    chk(res, 64'hffffffff_81234567);
    sh = 5'd4;
    go(OP_MERGE_RIGHT, 32'h0000000f, 32'h12345670);
    chk(res, 64'hffffffff_f1234567);
    sh = 5'd31;
    go(OP_MERGE_RIGHT, 32'h1, 32'h80000000);
    chk(res, 64'h3);
    st(4'he);
    @(negedge clk);
    chk(ps, 64'h3);
  endtask
  task automatic t_align;
    logic [31:0] a, b, e;
    a = 32'h11223344;
    b = 32'haabbccdd;
    for (int n = 0; n < 4; n++) begin
      bc = n[1:0];
      e = (b << (32 - 8 * n)) | (a >> (8 * n));
      go(OP_BYTE_ALIGN, a, b);
      chk(res, {{32{e[31]}}, e});
      st(4'he);
    end
  endtask
  task automatic t_pack;
    go(OP_CROSS_PACK, 32'h56789abc, 32'hdef01111);
    chk(res, 64'hffffffff_9abcdef0);
    st(4'hc);
    go(OP_NONE, 32'h1, 32'h2);
    st(4'h0);
  endtask
  initial begin
    repeat (20) @(negedge clk);
    srst = 0;
    @(negedge clk);
    st(4'h0);
    chk(res, 64'h0);
    t_mirror();
    t_field();
    t_splat();
    t_cmp();
    t_select();
    t_merge();
    t_align();
    t_pack();
    print_verdict();
  end
endmodule
`default_nettype wire
